// ===== logic/mir_pkg.sv
// mir_pkg: shared constants and carriers for the interrupt request logic
// assumes: 100 MHz processor clock, APB slave with 32-bit data
package mir_pkg;

    // register byte offsets on the APB
    localparam logic [11:0] OFS_ADP_GRP   = 12'h000; // adapter group (77)
    localparam logic [11:0] OFS_CPU_GRP   = 12'h004; // processor group (7F)
    localparam logic [11:0] OFS_L1_GRP    = 12'h008; // level-one group (7E)
    localparam logic [11:0] OFS_OUT_OP    = 12'h00C; // output operation
    localparam logic [11:0] OFS_IN_OP     = 12'h010; // input operation
    localparam logic [11:0] OFS_ACT_GREG  = 12'h014; // active register copy
    localparam logic [11:0] OFS_MASK      = 12'h018; // level mask
    localparam logic [11:0] OFS_LEVEL     = 12'h01C; // level / status
    localparam logic [11:0] OFS_START_ADR = 12'h020; // start addr 1..4
    localparam logic [11:0] OFS_EXEC      = 12'h030; // opcode check
    localparam logic [11:0] OFS_DONE      = 12'h034; // instruction done

    // operation codes
    localparam logic [7:0] OP_IN_ADP   = 8'h77;
    localparam logic [7:0] OP_IN_CPU   = 8'h7F;
    localparam logic [7:0] OP_IN_L1    = 8'h7E;
    localparam logic [7:0] OP_SET_PC2  = 8'h7B;
    localparam logic [7:0] OP_SET_PC3  = 8'h7C;
    localparam logic [7:0] OP_SET_PC4  = 8'h7D;
    localparam logic [7:0] OP_MISC     = 8'h77;
    localparam logic [7:0] OP_START_LO = 8'h40;
    localparam logic [7:0] OP_START_HI = 8'h43;

    // register group base addresses per level (1..5)
    localparam logic [7:0] GRP_L1 = 8'h20;
    localparam logic [7:0] GRP_L2 = 8'h00;
    localparam logic [7:0] GRP_L3 = 8'h08;
    localparam logic [7:0] GRP_L4 = 8'h10;
    localparam logic [7:0] GRP_L5 = 8'h18;

    localparam int unsigned NUM_VALID_OPS = 53;

    // level-one group bit positions
    localparam int L1_ADP    = 0;
    localparam int L1_ACMP   = 1;
    localparam int L1_AEXC   = 2;
    localparam int L1_IOCHK5 = 3;
    localparam int L1_PROT   = 4;
    localparam int L1_INVOP  = 5;
    localparam int L1_IPL    = 6;
    localparam int L1_MSINOP = 7;
    localparam int L1_HARD   = 8;
    localparam int L1_IOPAR  = 9;
    localparam int L1_IOTO   = 10;
    localparam int L1_W      = 11;

    // processor group bit positions
    localparam int CP_PC2   = 0;
    localparam int CP_MSD2  = 1;
    localparam int CP_MSD3  = 2;
    localparam int CP_TMR3  = 3;
    localparam int CP_PC3   = 4;
    localparam int CP_PNL3  = 5;
    localparam int CP_PC4   = 6;
    localparam int CP_MSRQ4 = 7;
    localparam int CP_MSRS4 = 8;
    localparam int CP_SVC4  = 9;
    localparam int CP_W     = 10;

    // adapter group bit positions
    localparam int AD_LA2 = 0;
    localparam int AD_CA3 = 1;
    localparam int AD_W   = 2;

    // misc-control clear bit positions in the output data
    localparam int MC_CLR_PC2 = 0;
    localparam int MC_CLR_PC3 = 1;
    localparam int MC_CLR_PC4 = 2;
    localparam int MC_CLR_TMR = 3;
    localparam int MC_CLR_SVC = 4;

    // mask register: bit 0 level one adapters, 1..3 levels 2..4, 4 level 5
    localparam logic [4:0] MASK_RST = 5'h00;

    // hardware request inputs, multi-cycle or level pulses
    typedef struct packed {
        logic adp_l1;
        logic addr_cmp;
        logic addr_exc;
        logic io_chk5;
        logic prot_chk;
        logic ipl_req;
        logic ms_inop;
        logic hard_err;
        logic io_par;
        logic io_tmo;
        logic ms_diag2;
        logic ms_diag3;
        logic timer3;
        logic panel3;
        logic ms_req4;
        logic ms_rsp4;
        logic svc_exit5;
    } mir_hw_req_s;

    typedef enum logic [2:0] {
        LVL_5 = 3'b000,
        LVL_4 = 3'b001,
        LVL_3 = 3'b011,
        LVL_2 = 3'b010,
        LVL_1 = 3'b110
    } mir_level_e;

endpackage

// ===== logic/mir_sync3.sv
// mir_sync3: three-stage synchroniser, change seen once stages 2 and 3 agree
// assumes: input comes from outside the clk_in domain
`timescale 1ns/1ps
module mir_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } mir_sync_s;

    mir_sync_s st_q;
    mir_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign q_out = st_q.q;
endmodule

// ===== logic/mir_irq_logic.sv
// mir_irq_logic: multilevel interrupt request latches, level selection,
// request-group reads, start addresses and invalid opcode check
// assumes: APB master on clk_in; hardware sources arrive asynchronously
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module mir_irq_logic (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic               ce_in,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // request sources
    input  wire mir_pkg::mir_hw_req_s hw_req_in,
    input  wire logic [1:0]         adp_req_in,
    input  wire logic               bypass_mode_in,
    // processor side
    output logic [2:0]              active_level_out,
    output logic [7:0]              greg_base_out,
    output logic [15:0]             start_addr_out,
    output logic                    take_irq_out,
    output logic                    proc_stop_out,
    output logic                    suppress_out,
    output logic [1:0]              cz_out
);
    localparam int HW_W = $bits(mir_pkg::mir_hw_req_s);

    typedef struct packed {
        logic [mir_pkg::L1_W-1:0] l1_grp;
        logic [mir_pkg::CP_W-1:0] cp_grp;
        logic [4:0]               mask;
        logic [2:0]               level;
        logic [4:0][1:0]          cz;
        logic [3:0][15:0]         start_adr;
        logic [7:0]               greg;
        logic [7:0]               opcode;
        logic                     op_valid;
        logic                     pending;
        logic                     suppress;
        logic                     stopped;
        logic                     take;
        logic [31:0]              rdata;
    } mir_irq_s;

    mir_irq_s st_q;
    mir_irq_s st_d;

    logic [HW_W-1:0]           hw_sync;
    logic [1:0]                adp_sync;
    mir_pkg::mir_hw_req_s      hw;
    logic [mir_pkg::AD_W-1:0]  ad_grp;
    logic [4:0]                lvl_req;
    logic [2:0]                win;
    logic                      wr_acc;
    logic                      rd_acc;
    logic                      known;
    logic [31:0]               rd_val;

    mir_sync3 #(.W(HW_W)) u_sync_hw (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .d_in   (hw_req_in),
        .q_out  (hw_sync)
    );

    mir_sync3 #(.W(2)) u_sync_adp (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .d_in   (adp_req_in),
        .q_out  (adp_sync)
    );

    assign hw     = mir_pkg::mir_hw_req_s'(hw_sync);
    // adapter requests are held by the adapters and cleared there
    assign ad_grp = adp_sync;
    assign wr_acc = psel && penable && pwrite && ce_in;
    assign rd_acc = psel && penable && !pwrite && ce_in;

    // level requests; any unmasked set bit keeps its level requested
    always_comb begin
        lvl_req    = '0;
        lvl_req[0] = (|(st_q.l1_grp & ~(mir_pkg::L1_W'(1)
                        << mir_pkg::L1_ADP)))
                     || (st_q.l1_grp[mir_pkg::L1_ADP] && !st_q.mask[0]);
        lvl_req[1] = (ad_grp[mir_pkg::AD_LA2] || st_q.cp_grp[mir_pkg::CP_PC2]
                     || st_q.cp_grp[mir_pkg::CP_MSD2]) && !st_q.mask[1];
        lvl_req[2] = (ad_grp[mir_pkg::AD_CA3] || st_q.cp_grp[mir_pkg::CP_MSD3]
                     || st_q.cp_grp[mir_pkg::CP_TMR3]
                     || st_q.cp_grp[mir_pkg::CP_PC3]
                     || st_q.cp_grp[mir_pkg::CP_PNL3]) && !st_q.mask[2];
        lvl_req[3] = (st_q.cp_grp[mir_pkg::CP_PC4]
                     || st_q.cp_grp[mir_pkg::CP_MSRQ4]
                     || st_q.cp_grp[mir_pkg::CP_MSRS4]
                     || st_q.cp_grp[mir_pkg::CP_SVC4]) && !st_q.mask[3];
        lvl_req[4] = 1'b0;
    end

    // fixed priority, level one first; 5 means base level
    always_comb begin
        win = 3'd5;
        for (int i = 3; i >= 0; i--) begin
            if (lvl_req[i]) begin
                win = 3'(i + 1);
            end
        end
    end

    // rough opcode legality: first 53 codes of the opcode space are defined
    assign known = st_q.opcode < 8'(mir_pkg::NUM_VALID_OPS);

    function automatic logic [7:0] grp_base(input logic [2:0] lv);
        logic [7:0] b;
        b = mir_pkg::GRP_L5;
        unique case (lv)
            3'd1: b = mir_pkg::GRP_L1;
            3'd2: b = mir_pkg::GRP_L2;
            3'd3: b = mir_pkg::GRP_L3;
            3'd4: b = mir_pkg::GRP_L4;
            default: b = mir_pkg::GRP_L5;
        endcase
        return b;
    endfunction

    always_comb begin
        logic [7:0] op;
        op       = pwdata[15:8];
        rd_val   = 32'h0000_0000;
        st_d     = st_q;
        st_d.take     = 1'b0;
        st_d.suppress = 1'b0;

        // hardware sets; placed after clears so a set wins
        // program clears first
        if (wr_acc && paddr == mir_pkg::OFS_OUT_OP && op == mir_pkg::OP_MISC) begin
            if (pwdata[mir_pkg::MC_CLR_PC2]) st_d.cp_grp[mir_pkg::CP_PC2] = 1'b0;
            if (pwdata[mir_pkg::MC_CLR_PC3]) st_d.cp_grp[mir_pkg::CP_PC3] = 1'b0;
            if (pwdata[mir_pkg::MC_CLR_PC4]) st_d.cp_grp[mir_pkg::CP_PC4] = 1'b0;
            if (pwdata[mir_pkg::MC_CLR_TMR]) st_d.cp_grp[mir_pkg::CP_TMR3] = 1'b0;
            if (pwdata[mir_pkg::MC_CLR_SVC]) st_d.cp_grp[mir_pkg::CP_SVC4] = 1'b0;
        end
        // write-one-to-clear of the other latches, each by its own bit
        if (wr_acc && paddr == mir_pkg::OFS_L1_GRP) begin
            st_d.l1_grp = st_d.l1_grp & ~pwdata[mir_pkg::L1_W-1:0];
        end
        if (wr_acc && paddr == mir_pkg::OFS_CPU_GRP) begin
            st_d.cp_grp = st_d.cp_grp & ~pwdata[mir_pkg::CP_W-1:0];
        end

        // software requests may come from levels one to four only
        if (wr_acc && paddr == mir_pkg::OFS_OUT_OP && st_q.level != 3'd5) begin
            if (op == mir_pkg::OP_SET_PC2) st_d.cp_grp[mir_pkg::CP_PC2] = 1'b1;
            if (op == mir_pkg::OP_SET_PC3) st_d.cp_grp[mir_pkg::CP_PC3] = 1'b1;
            if (op == mir_pkg::OP_SET_PC4) st_d.cp_grp[mir_pkg::CP_PC4] = 1'b1;
        end
        if (wr_acc && paddr == mir_pkg::OFS_OUT_OP && op >= mir_pkg::OP_START_LO
            && op <= mir_pkg::OP_START_HI) begin
            st_d.start_adr[op[1:0]] = pwdata[31:16];
        end
        if (wr_acc && paddr == mir_pkg::OFS_MASK) begin
            st_d.mask = pwdata[4:0];
        end
        // request group inputs land in the active general register copy
        if (wr_acc && paddr == mir_pkg::OFS_IN_OP) begin
            unique case (op)
                mir_pkg::OP_IN_ADP: st_d.rdata = 32'(ad_grp);
                mir_pkg::OP_IN_CPU: st_d.rdata = 32'(st_q.cp_grp);
                mir_pkg::OP_IN_L1:  st_d.rdata = 32'(st_q.l1_grp);
                default:            st_d.rdata = st_q.rdata;
            endcase
        end
        if (wr_acc && paddr == mir_pkg::OFS_EXEC) begin
            st_d.opcode   = pwdata[7:0];
            st_d.op_valid = 1'b1;
        end

        // hardware sets
        st_d.l1_grp[mir_pkg::L1_ADP]    |= hw.adp_l1;
        st_d.l1_grp[mir_pkg::L1_ACMP]   |= hw.addr_cmp;
        st_d.l1_grp[mir_pkg::L1_AEXC]   |= hw.addr_exc;
        st_d.l1_grp[mir_pkg::L1_IOCHK5] |= hw.io_chk5;
        st_d.l1_grp[mir_pkg::L1_PROT]   |= hw.prot_chk;
        st_d.l1_grp[mir_pkg::L1_IPL]    |= hw.ipl_req;
        st_d.l1_grp[mir_pkg::L1_MSINOP] |= hw.ms_inop;
        st_d.l1_grp[mir_pkg::L1_HARD]   |= hw.hard_err;
        st_d.l1_grp[mir_pkg::L1_IOPAR]  |= hw.io_par;
        st_d.l1_grp[mir_pkg::L1_IOTO]   |= hw.io_tmo;
        st_d.cp_grp[mir_pkg::CP_MSD2]   |= hw.ms_diag2;
        st_d.cp_grp[mir_pkg::CP_MSD3]   |= hw.ms_diag3;
        st_d.cp_grp[mir_pkg::CP_TMR3]   |= hw.timer3;
        st_d.cp_grp[mir_pkg::CP_PNL3]   |= hw.panel3;
        st_d.cp_grp[mir_pkg::CP_MSRQ4]  |= hw.ms_req4;
        st_d.cp_grp[mir_pkg::CP_MSRS4]  |= hw.ms_rsp4;
        st_d.cp_grp[mir_pkg::CP_SVC4]   |= hw.svc_exit5 && st_q.level == 3'd5;

        // opcode check one cycle after the opcode is presented
        if (st_q.op_valid) begin
            st_d.op_valid = 1'b0;
            if (!known) begin
                st_d.suppress = 1'b1;
                st_d.l1_grp[mir_pkg::L1_INVOP] = 1'b1;
                if (st_q.level == 3'd1) begin
                    st_d.l1_grp[mir_pkg::L1_HARD] = 1'b1;
                end
            end
        end
        // hard error halts unless bypass; reset releases the stop
        if (st_q.l1_grp[mir_pkg::L1_HARD] && !bypass_mode_in) begin
            st_d.stopped = 1'b1;
        end

        // switch only at instruction completion, never mid-instruction
        if (wr_acc && paddr == mir_pkg::OFS_DONE && !st_q.stopped) begin
            if (win != st_q.level) begin
                st_d.level = win;
                st_d.greg  = grp_base(win);
                st_d.take  = win != 3'd5;
            end
            st_d.cz[3'(st_q.level - 3'd1)] = pwdata[1:0];
        end

        // reads never touch the active register copy, so it survives them
        if (rd_acc) begin
            unique case (paddr)
                mir_pkg::OFS_ADP_GRP:  rd_val = 32'(ad_grp);
                mir_pkg::OFS_CPU_GRP:  rd_val = 32'(st_q.cp_grp);
                mir_pkg::OFS_L1_GRP:   rd_val = 32'(st_q.l1_grp);
                mir_pkg::OFS_ACT_GREG: rd_val = st_q.rdata;
                mir_pkg::OFS_MASK:     rd_val = 32'(st_q.mask);
                mir_pkg::OFS_LEVEL:    rd_val = {27'h0, st_q.stopped,
                                                 1'b0, st_q.level};
                default:               rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q       <= '0;
            st_q.level <= 3'd5;
            st_q.greg  <= mir_pkg::GRP_L5;
            st_q.mask  <= mir_pkg::MASK_RST;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign pready           = 1'b1;
    assign pslverr          = 1'b0;
    assign prdata           = rd_acc ? rd_val : 32'h0000_0000;
    assign active_level_out = st_q.level;
    assign greg_base_out    = st_q.greg;
    assign start_addr_out   = (st_q.level == 3'd5) ? 16'h0000
                              : st_q.start_adr[2'(st_q.level - 3'd1)];
    assign take_irq_out     = st_q.take;
    assign proc_stop_out    = st_q.stopped;
    assign suppress_out     = st_q.suppress;
    assign cz_out           = st_q.cz[3'(st_q.level - 3'd1)];
endmodule

// ===== test/mir_chk.sv
// mir_chk: concurrent checks on the interrupt request logic ports
// assumes: bound into mir_irq_logic, one clk_in domain, ce_in held high
`timescale 1ns/1ps
module mir_chk (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        bypass_mode_in,
    input  wire logic [7:0]  greg_base_out,
    input  wire logic [15:0] start_addr_out,
    input  wire logic        take_irq_out,
    input  wire logic        proc_stop_out,
    input  wire logic        suppress_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic done_q;
    // remembers a completed done write so a level change can be traced back
    always_ff @(posedge clk_in) begin
        done_q <= psel && penable && pwrite && paddr == mir_pkg::OFS_DONE;
    end
    sequence s_bad_op;
        psel && penable && pwrite && paddr == mir_pkg::OFS_EXEC
            && pwdata[7:0] >= 8'h35;
    endsequence
    sequence s_enter;
        take_irq_out && greg_base_out != mir_pkg::GRP_L5;
    endsequence
    AST_RST_BASE: assert property ($fell(rst_in) |->
        greg_base_out == mir_pkg::GRP_L5 && !proc_stop_out)
        else $error("reset did not return to the base level");
    AST_GRP_MAP: assert property (greg_base_out inside
        {8'h20, 8'h00, 8'h08, 8'h10, 8'h18})
        else $error("register group base outside the five groups");
    AST_BASE_ADDR: assert property (greg_base_out == 8'h18 |->
        start_addr_out == 16'h0000)
        else $error("base level shows a start address");
    AST_TAKE_LVL: assert property (take_irq_out |-> s_enter)
        else $error("interrupt taken into the base level");
    AST_SWITCH_DONE: assert property ($changed(greg_base_out) |->
        done_q || $past(rst_in))
        else $error("level changed without a completed instruction");
    AST_STOP_BYPASS: assert property ($rose(proc_stop_out) |->
        !bypass_mode_in && !$past(bypass_mode_in))
        else $error("processor stopped while in bypass mode");
    AST_STOP_HOLD: assert property (proc_stop_out |=> proc_stop_out)
        else $error("processor stop released without reset");
    AST_SUPPRESS: assert property (s_bad_op |-> ##[1:3] suppress_out)
        else $error("undefined opcode not suppressed");
    AST_READY: assert property (psel && penable |->
        pready && !pslverr)
        else $error("bus access not answered at once");
endmodule

bind mir_irq_logic mir_chk mir_chk_inst (
    .clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .bypass_mode_in, .greg_base_out, .start_addr_out,
    .take_irq_out, .proc_stop_out, .suppress_out
);

// ===== test/mir_src_model.sv
// mir_src_model: adapters and maintenance subsystem raising requests
// assumes: commanded by the bench on clk_in; one pulsed source at a time
`timescale 1ns/1ps
module mir_src_model (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [4:0]  idx_in,
    input  wire logic [1:0]  adp_in,
    output mir_pkg::mir_hw_req_s hw_req_out,
    output logic [1:0]       adp_req_out
);
    logic [2:0]  hold_q = 3'h0;
    logic [4:0]  idx_q  = 5'h00;
    logic [16:0] vec;
    // six cycles wide so the three-stage synchroniser cannot miss it
    always_ff @(posedge clk_in) begin
        if (go_in) begin
            idx_q  <= idx_in;
            hold_q <= 3'h6;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    always_comb begin
        vec = 17'h00000;
        if (hold_q != 3'h0) begin
            vec[idx_q] = 1'b1;
        end
        hw_req_out = mir_pkg::mir_hw_req_s'(vec);
    end
    // adapters hold their request until serviced
    assign adp_req_out = adp_in;
endmodule

// ===== test/tb_top.sv
// tb_top: register-level tests of the interrupt request logic over APB
// assumes: zero-wait slave as handed over, sources via mir_src_model
`timescale 1ns/1ps
module tb_top;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, take, stop, supp;
    logic        bypass = 1'b0, go = 1'b0;
    logic [4:0]  idx = 5'h00;
    logic [1:0]  adp = 2'h0, adp_req, cz;
    logic [2:0]  lvl;
    logic [7:0]  greg;
    logic [15:0] sadr;
    mir_pkg::mir_hw_req_s hw_req;
    int          fails = 0, total_checks = 0, cyc = 0, sup_n = 0, i;
    // group bit of each pulsed source, source vector bit 0 upwards
    localparam int GBIT [17] = '{9, 8, 7, 5, 3, 2, 1, 10, 9, 8, 7, 6, 4,
                                 3, 2, 1, 0};

    mir_irq_logic mir_irq_logic_inst (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_req_in(hw_req), .adp_req_in(adp_req),
        .bypass_mode_in(bypass), .active_level_out(lvl),
        .greg_base_out(greg), .start_addr_out(sadr), .take_irq_out(take),
        .proc_stop_out(stop), .suppress_out(supp), .cz_out(cz));
    mir_src_model mir_src_model_inst (.clk_in(clk_in), .go_in(go),
        .idx_in(idx), .adp_in(adp), .hw_req_out(hw_req),
        .adp_req_out(adp_req));

    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        sup_n += (supp === 1'b1) ? 1 : 0;
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            close_out();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic op(input logic [7:0] code, input logic [15:0] hi,
                      input logic [7:0] lo);
        wr(mir_pkg::OFS_OUT_OP, {hi, code, lo});
    endtask
    task automatic pulse(input int j);
        idx <= 5'(j);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (12) @(posedge clk_in);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rdc(mir_pkg::OFS_CPU_GRP, 32'h0);
        rdc(mir_pkg::OFS_L1_GRP, 32'h0);
        check(greg, 8'h18);
        for (i = 0; i < 4; i++) op(8'h40 | 8'(i), 16'h1000 | 16'(i), 8'h00);
        op(mir_pkg::OP_SET_PC2, 16'h0, 8'h00);
        rdc(mir_pkg::OFS_CPU_GRP, 32'h0);
        adp <= 2'b11;
        repeat (8) @(posedge clk_in);
        rdc(mir_pkg::OFS_ADP_GRP, 32'h3);
        wr(mir_pkg::OFS_IN_OP, {16'h0, mir_pkg::OP_IN_ADP, 8'h00});
        rdc(mir_pkg::OFS_ACT_GREG, 32'h3);
        wr(mir_pkg::OFS_MASK, 32'h6);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h18);
        wr(mir_pkg::OFS_MASK, 32'h0);
        wr(mir_pkg::OFS_DONE, 32'h2);
        check(greg, 8'h00);
        check(sadr, 16'h1001);
        check(cz, 2'b00);
        adp <= 2'b00;
        repeat (8) @(posedge clk_in);
        wr(mir_pkg::OFS_DONE, 32'h1);
        check(greg, 8'h18);
        check(cz, 2'b10);
        wr(mir_pkg::OFS_EXEC, 32'h34);
        repeat (4) @(posedge clk_in);
        check(sup_n, 0);
        wr(mir_pkg::OFS_EXEC, 32'h35);
        repeat (4) @(posedge clk_in);
        check(sup_n, 1);
        rdc(mir_pkg::OFS_L1_GRP, 32'h20);
        check(stop, 1'b0);
        wr(mir_pkg::OFS_L1_GRP, 32'h20);
        pulse(4);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h08);
        check(sadr, 16'h1002);
        for (i = 0; i < 3; i++) op(8'h7B + 8'(i), 16'h0, 8'h00);
        rdc(mir_pkg::OFS_CPU_GRP, 32'h59);
        wr(mir_pkg::OFS_IN_OP, {16'h0, mir_pkg::OP_IN_CPU, 8'h00});
        rdc(mir_pkg::OFS_ACT_GREG, 32'h59);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h00);
        op(mir_pkg::OP_MISC, 16'h0, 8'h09);
        rdc(mir_pkg::OFS_CPU_GRP, 32'h50);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h08);
        op(mir_pkg::OP_MISC, 16'h0, 8'h16);
        rdc(mir_pkg::OFS_CPU_GRP, 32'h0);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h18);
        pulse(15);
        rdc(mir_pkg::OFS_L1_GRP, 32'h2);
        wr(mir_pkg::OFS_IN_OP, {16'h0, mir_pkg::OP_IN_L1, 8'h00});
        rdc(mir_pkg::OFS_ACT_GREG, 32'h2);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h20);
        check(sadr, 16'h1000);
        wr(mir_pkg::OFS_L1_GRP, 32'h2);
        rdc(mir_pkg::OFS_L1_GRP, 32'h0);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h18);
        bypass <= 1'b1;
        for (i = 0; i < 17; i++) begin
            pulse(i);
            rdc(i < 7 ? mir_pkg::OFS_CPU_GRP : mir_pkg::OFS_L1_GRP,
                32'h1 << GBIT[i]);
            wr(i < 7 ? mir_pkg::OFS_CPU_GRP : mir_pkg::OFS_L1_GRP,
               32'h1 << GBIT[i]);
        end
        check(stop, 1'b0);
        bypass <= 1'b0;
        pulse(15);
        wr(mir_pkg::OFS_DONE, 32'h0);
        check(greg, 8'h20);
        wr(mir_pkg::OFS_EXEC, 32'hFF);
        repeat (4) @(posedge clk_in);
        rdc(mir_pkg::OFS_L1_GRP, 32'h122);
        check(stop, 1'b1);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check(stop, 1'b0);
        rdc(mir_pkg::OFS_L1_GRP, 32'h0);
        close_out();
    end
endmodule
